// ---- logic/io_cond_regs.vh ----
// Summary of operation
// RULE1 - Every analog reading is an unsigned 16-bit code, 0 is 0V, 65535 is 5V.
// RULE2 - High-resolution ports take 14-bit samples near 1kHz, left-justified to 16 bits.
// RULE3 - Low-resolution ports take 6-bit samples near 8kHz, scaled to 16 bits.
// RULE4 - Each analog port has its own low-pass filter shift, values 0 to 15.
// RULE5 - New output is old output times (1-2^-f) plus input times 2^-f.
// RULE6 - A shift of zero bypasses the filter; value equals the newest sample.
// RULE7 - One 8-bit analog output changes only when the host writes a new code.
// RULE8 - Digital inputs report their level and apply pull-up, pull-down or no pull.
// RULE9 - Any port can be a digital output driving the last level the host wrote.
// RULE10 - Gyro port set as analog input enables the integrator with no separate mode.
// RULE11 - Integrator takes one gyro reading every tick of a 512Hz timebase.
// RULE12 - Integrator uses the filtered value when a filter is set, else the raw value.
// RULE13 - Each tick adds the reading and subtracts 32768 from the accumulator.
// RULE14 - The 32-bit accumulator wraps freely with no saturation or error flag.
// RULE15 - Host reads the accumulator often enough that changes stay below half range.
// RULE16 - Host can read a count of 512Hz timebase ticks.
// RULE17 - Host writes the mode of every used port after each device reset.
// RULE18 - Reset puts all ports in a safe default held until the host reconfigures.
// RULE19 - Each port has exactly one mode at a time, changeable at run time.
// RULE20 - Filters update once per new sample at 16-bit precision using arithmetic shifts.
`ifndef IO_COND_REGS_VH
`define IO_COND_REGS_VH

`define CLK_HZ 20000000
`define HI_RATE_HZ 1000
`define LO_RATE_HZ 8000
`define GYRO_RATE_HZ 512
`define HI_SAMPLE_CYCLES (`CLK_HZ / `HI_RATE_HZ)
`define LO_SAMPLE_CYCLES (`CLK_HZ / `LO_RATE_HZ)
`define GYRO_TICK_CYCLES (`CLK_HZ / `GYRO_RATE_HZ)

`define NUM_PORTS 20
`define NUM_HI_CH 8
`define NUM_LO_CH 4
`define NUM_ACH 12
`define HI_BITS 14
`define LO_BITS 6
`define GYRO_CH 7
`define DAC_PORT 12
`define GYRO_MIDSCALE 32'h00008000

`define MODE_DIN 2'h0
`define MODE_DOUT 2'h1
`define MODE_AIN 2'h2
`define MODE_AOUT 2'h3

`define PULL_NONE 2'h0
`define PULL_UP 2'h1
`define PULL_DOWN 2'h2

`define ADDR_MODE_LO 8'h00
`define ADDR_MODE_HI 8'h04
`define ADDR_PULL_LO 8'h08
`define ADDR_PULL_HI 8'h0C
`define ADDR_DOUT 8'h10
`define ADDR_DIN 8'h14
`define ADDR_DAC 8'h18
`define ADDR_GYRO_ACC 8'h1C
`define ADDR_GYRO_TICKS 8'h20
`define ADDR_SHIFT_LO 8'h24
`define ADDR_SHIFT_HI 8'h28
`define ADDR_AVAL_BASE 8'h40

`define RST_MODE 40'h00_0000_0000
`define RST_PULL 40'h00_0000_0000
`define RST_DOUT 20'h00000
`define RST_DAC 8'h00
`define RST_SHIFT 48'h0000_0000_0000

`endif

// ---- logic/iir_lowpass.v ----
`timescale 1ns/1ns
`include "io_cond_regs.vh"

module iir_lowpass (
  input wire pclk, // System clock
  input wire presetn, // Asynchronous reset, active low
  input wire sample_valid, // New converted sample this cycle
  input wire [15:0] sample, // Scaled 16-bit sample
  input wire [3:0] shift, // Filter strength f
  output reg [15:0] value_reg // Filtered value
);

  wire signed [16:0] diff;
  wire signed [16:0] step;
  wire [15:0] value_next;

  // y + (x - y) >>> f equals (1-2^-f)y + 2^-f x and never leaves 0..65535
  assign diff = $signed({1'b0, sample}) - $signed({1'b0, value_reg}); // RULE5
  assign step = diff >>> shift; // RULE20
  // With f = 0 the step is the full difference, so the output is the sample
  assign value_next = value_reg + step[15:0]; // RULE6

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg <= 16'h0000;
    end else if (sample_valid) begin
      value_reg <= value_next; // RULE20
    end
  end

endmodule // iir_lowpass

// ---- logic/io_conditioner.v ----
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "io_cond_regs.vh"

module io_conditioner #(
  parameter HI_SAMPLE_CYCLES = `HI_SAMPLE_CYCLES,
  parameter LO_SAMPLE_CYCLES = `LO_SAMPLE_CYCLES,
  parameter GYRO_TICK_CYCLES = `GYRO_TICK_CYCLES
) (
  input wire pclk, // System clock, 20 MHz
  input wire presetn, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction, high for write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire pready, // APB ready
  output reg [31:0] prdata, // APB read data
  output reg pslverr, // APB error on unmapped address
  output reg adc_hi_start, // Pulse: start 14-bit conversions
  input wire adc_hi_valid, // Pulse: 14-bit results present
  input wire [111:0] adc_hi_data, // Eight 14-bit results, channel 0 lowest
  output reg adc_lo_start, // Pulse: start 6-bit conversions
  input wire adc_lo_valid, // Pulse: 6-bit results present
  input wire [23:0] adc_lo_data, // Four 6-bit results, channel 8 lowest
  input wire [19:0] dio_in, // Port pin levels
  output reg [19:0] dio_out, // Port drive levels
  output reg [19:0] dio_oe, // Port drive enables, high drives the pin
  output reg [19:0] pull_up_en, // Pull-up resistor enables
  output reg [19:0] pull_down_en, // Pull-down resistor enables
  output reg [7:0] dac_code, // Analog output code
  output reg dac_en, // Analog output driven
  output reg gyro_tick // Pulse: 512Hz integrator tick
);

  reg [39:0] mode_reg;
  reg [39:0] pull_reg;
  reg [19:0] dout_reg;
  reg [19:0] din_reg;
  reg [7:0] dac_reg;
  reg [47:0] shift_reg;
  reg [31:0] gyro_acc_reg;
  reg [31:0] gyro_acc_next;
  reg [31:0] gyro_ticks_reg;
  reg [15:0] gyro_raw_reg;
  reg [31:0] hi_cnt_reg;
  reg [31:0] lo_cnt_reg;
  reg [31:0] tick_cnt_reg;
  reg [15:0] gyro_reading;
  wire [191:0] scaled;
  wire [191:0] filtered;
  wire [11:0] ch_valid;
  wire gyro_enabled;
  wire wr_en;
  wire setup;
  reg [31:0] rd_data;
  reg rd_err;

  // Digital in is the safe mode: nothing is driven until software asks
  function [1:0] port_mode;
    input [39:0] modes;
    input integer port;
    reg [1:0] m;
    begin
      m = modes[2*port +: 2];
      // Only one port owns the converter output; elsewhere the code reads as input
      if (m == `MODE_AOUT && port != `DAC_PORT) begin
        port_mode = `MODE_DIN;
      end else begin
        port_mode = m;
      end
    end
  endfunction

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  // Conversion pacing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_reg <= 32'h00000000;
      lo_cnt_reg <= 32'h00000000;
      adc_hi_start <= 1'b0;
      adc_lo_start <= 1'b0;
    end else begin
      adc_hi_start <= 1'b0;
      adc_lo_start <= 1'b0;
      if (hi_cnt_reg == HI_SAMPLE_CYCLES - 1) begin
        hi_cnt_reg <= 32'h00000000;
        adc_hi_start <= 1'b1; // RULE2
      end else begin
        hi_cnt_reg <= hi_cnt_reg + 32'h00000001;
      end
      if (lo_cnt_reg == LO_SAMPLE_CYCLES - 1) begin
        lo_cnt_reg <= 32'h00000000;
        adc_lo_start <= 1'b1; // RULE3
      end else begin
        lo_cnt_reg <= lo_cnt_reg + 32'h00000001;
      end
    end
  end

  // Analog channels: 0-7 high resolution, 8-11 low resolution
  genvar ch;
  generate
    for (ch = 0; ch < `NUM_ACH; ch = ch + 1) begin : g_ach
      if (ch < `NUM_HI_CH) begin : g_hi
        wire [13:0] raw;
        assign raw = adc_hi_data[14*ch +: 14];
        assign scaled[16*ch +: 16] = {raw, 2'b00}; // RULE2
        assign ch_valid[ch] = adc_hi_valid;
      end else begin : g_lo
        wire [5:0] raw;
        assign raw = adc_lo_data[6*(ch-`NUM_HI_CH) +: 6];
        // Bit replication maps code 63 to 65535 so full scale stays full scale
        assign scaled[16*ch +: 16] = {raw, raw, raw[5:2]}; // RULE3
        assign ch_valid[ch] = adc_lo_valid;
      end
      iir_lowpass u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .sample_valid(ch_valid[ch]),
        .sample(scaled[16*ch +: 16]),
        .shift(shift_reg[4*ch +: 4]), // RULE4
        .value_reg(filtered[16*ch +: 16])
      );
    end
  endgenerate

  // Port pin drive follows the configured mode of each port
  integer p;
  always @* begin
    dio_out = 20'h00000;
    dio_oe = 20'h00000;
    pull_up_en = 20'h00000;
    pull_down_en = 20'h00000;
    for (p = 0; p < `NUM_PORTS; p = p + 1) begin
      case (port_mode(mode_reg, p))
        `MODE_DOUT: begin
          dio_out[p] = dout_reg[p]; // RULE9
          dio_oe[p] = 1'b1; // RULE9
        end
        `MODE_DIN: begin
          pull_up_en[p] = (pull_reg[2*p +: 2] == `PULL_UP); // RULE8
          pull_down_en[p] = (pull_reg[2*p +: 2] == `PULL_DOWN); // RULE8
        end
        default: begin
          dio_out[p] = 1'b0;
        end
      endcase
    end
    dac_en = (port_mode(mode_reg, `DAC_PORT) == `MODE_AOUT);
    dac_code = dac_reg; // RULE7
  end

  // Gyro integrator
  assign gyro_enabled = (port_mode(mode_reg, 15) == `MODE_AIN); // RULE10

  always @* begin
    if (shift_reg[4*`GYRO_CH +: 4] != 4'h0) begin
      gyro_reading = filtered[16*`GYRO_CH +: 16]; // RULE12
    end else begin
      gyro_reading = gyro_raw_reg; // RULE12
    end
    // Plain 32-bit arithmetic wraps modulo 2^32 by itself
    gyro_acc_next = gyro_acc_reg + {16'h0000, gyro_reading} - `GYRO_MIDSCALE; // RULE13 RULE14
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h00000000;
      gyro_tick <= 1'b0;
      gyro_ticks_reg <= 32'h00000000;
      gyro_acc_reg <= 32'h00000000;
      gyro_raw_reg <= 16'h0000;
    end else begin
      gyro_tick <= 1'b0;
      if (adc_hi_valid) begin
        gyro_raw_reg <= scaled[16*`GYRO_CH +: 16];
      end
      if (tick_cnt_reg == GYRO_TICK_CYCLES - 1) begin
        tick_cnt_reg <= 32'h00000000;
        gyro_tick <= 1'b1; // RULE11
        gyro_ticks_reg <= gyro_ticks_reg + 32'h00000001; // RULE16
        if (gyro_enabled) begin
          gyro_acc_reg <= gyro_acc_next; // RULE11 RULE14
        end
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      end
    end
  end

  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `RST_MODE; // RULE18
      pull_reg <= `RST_PULL; // RULE18
      dout_reg <= `RST_DOUT; // RULE18
      dac_reg <= `RST_DAC; // RULE18
      shift_reg <= `RST_SHIFT; // RULE18
      din_reg <= 20'h00000;
    end else begin
      din_reg <= dio_in; // RULE8
      if (wr_en) begin
        case (paddr)
          `ADDR_MODE_LO: mode_reg[31:0] <= pwdata; // RULE19
          `ADDR_MODE_HI: mode_reg[39:32] <= pwdata[7:0]; // RULE19
          `ADDR_PULL_LO: pull_reg[31:0] <= pwdata;
          `ADDR_PULL_HI: pull_reg[39:32] <= pwdata[7:0];
          `ADDR_DOUT: dout_reg <= pwdata[19:0];
          `ADDR_DAC: dac_reg <= pwdata[7:0]; // RULE7
          `ADDR_SHIFT_LO: shift_reg[31:0] <= pwdata; // RULE4
          `ADDR_SHIFT_HI: shift_reg[47:32] <= pwdata[15:0]; // RULE4
          default: dac_reg <= dac_reg;
        endcase
      end
    end
  end

  // Read decode; analog values sit at consecutive words from the base
  always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `ADDR_MODE_LO: rd_data = mode_reg[31:0];
      `ADDR_MODE_HI: rd_data = {24'h000000, mode_reg[39:32]};
      `ADDR_PULL_LO: rd_data = pull_reg[31:0];
      `ADDR_PULL_HI: rd_data = {24'h000000, pull_reg[39:32]};
      `ADDR_DOUT: rd_data = {12'h000, dout_reg};
      `ADDR_DIN: rd_data = {12'h000, din_reg}; // RULE8
      `ADDR_DAC: rd_data = {24'h000000, dac_reg};
      `ADDR_GYRO_ACC: rd_data = gyro_acc_reg;
      `ADDR_GYRO_TICKS: rd_data = gyro_ticks_reg; // RULE16
      `ADDR_SHIFT_LO: rd_data = shift_reg[31:0];
      `ADDR_SHIFT_HI: rd_data = {16'h0000, shift_reg[47:32]};
      default: begin
        if (paddr[7:6] == 2'b01 && paddr[1:0] == 2'b00 && paddr[5:2] < 4'hC) begin
          rd_data = {16'h0000, filtered[16*paddr[5:2] +: 16]}; // RULE1
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  // Read data is captured in the setup cycle so it leaves a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_data;
      pslverr <= rd_err;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

endmodule // io_conditioner

// ---- bench/io_cond_asserts.sv ----
`timescale 1ns/1ns
`include "io_cond_regs.vh"
module io_cond_chk #(
  parameter HI_SAMPLE_CYCLES = `HI_SAMPLE_CYCLES,
  parameter LO_SAMPLE_CYCLES = `LO_SAMPLE_CYCLES,
  parameter GYRO_TICK_CYCLES = `GYRO_TICK_CYCLES
) (
  input wire pclk, // Clock
  input wire presetn, // Reset, active low
  input wire psel, // Select
  input wire penable, // Access phase
  input wire pwrite, // Write
  input wire [7:0] paddr, // Address
  input wire [31:0] pwdata, // Write data
  input wire adc_hi_start, // Fine batch start
  input wire adc_lo_start, // Coarse batch start
  input wire gyro_tick, // Integrator tick
  input wire [19:0] dio_oe, // Drive enables
  input wire [19:0] pull_up_en, // Pull-ups
  input wire [19:0] pull_down_en, // Pull-downs
  input wire [7:0] dac_code, // Analog out code
  input wire dac_en // Analog out driven
);
  reg [31:0] hi_gap;
  reg [31:0] lo_gap;
  reg [31:0] tick_gap;
  reg hi_seen;
  reg lo_seen;
  reg tick_seen;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire dac_wr = psel && penable && pwrite && paddr == `ADDR_DAC;
  // Counts are far too long for delays, so cycles since the last pulse are counted here;
  // the first pulse after reset lands one cycle later than the steady spacing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_gap <= 32'h00000000;
      lo_gap <= 32'h00000000;
      tick_gap <= 32'h00000000;
      hi_seen <= 1'b0;
      lo_seen <= 1'b0;
      tick_seen <= 1'b0;
    end else begin
      hi_gap <= adc_hi_start ? 32'h00000000 : hi_gap + 32'h00000001;
      lo_gap <= adc_lo_start ? 32'h00000000 : lo_gap + 32'h00000001;
      tick_gap <= gyro_tick ? 32'h00000000 : tick_gap + 32'h00000001;
      hi_seen <= hi_seen | adc_hi_start;
      lo_seen <= lo_seen | adc_lo_start;
      tick_seen <= tick_seen | gyro_tick;
    end
  end
  hi_period_a: assert property (hi_seen ? (adc_hi_start ? hi_gap == HI_SAMPLE_CYCLES - 1
    : hi_gap < HI_SAMPLE_CYCLES - 1) : hi_gap <= HI_SAMPLE_CYCLES)
    else $error("fine sample spacing wrong");
  lo_period_a: assert property (lo_seen ? (adc_lo_start ? lo_gap == LO_SAMPLE_CYCLES - 1
    : lo_gap < LO_SAMPLE_CYCLES - 1) : lo_gap <= LO_SAMPLE_CYCLES)
    else $error("coarse sample spacing wrong");
  tick_period_a: assert property (tick_seen ? (gyro_tick ? tick_gap == GYRO_TICK_CYCLES - 1
    : tick_gap < GYRO_TICK_CYCLES - 1) : tick_gap <= GYRO_TICK_CYCLES)
    else $error("tick spacing wrong");
  pull_excl_a: assert property ((pull_up_en & pull_down_en) == 20'h00000)
    else $error("pull up and down together");
  one_mode_a: assert property ((dio_oe & (pull_up_en | pull_down_en)) == 20'h00000)
    else $error("pull on a driven port");
  dac_pin_a: assert property (dac_en |-> !dio_oe[12])
    else $error("analog out port also driven");
  dac_hold_a: assert property (!dac_wr |=> $stable(dac_code))
    else $error("analog code moved without a write");
  dac_load_a: assert property (dac_wr |=> dac_code == $past(pwdata[7:0]))
    else $error("analog code not loaded");
  safe_reset_a: assert property (disable iff (1'b0) !presetn |->
    dio_oe == 20'h00000 && pull_up_en == 20'h00000 && !dac_en)
    else $error("ports not safe in reset");
endmodule // io_cond_chk

bind io_conditioner io_cond_chk #(.HI_SAMPLE_CYCLES(HI_SAMPLE_CYCLES),
  .LO_SAMPLE_CYCLES(LO_SAMPLE_CYCLES), .GYRO_TICK_CYCLES(GYRO_TICK_CYCLES)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .adc_hi_start(adc_hi_start), .adc_lo_start(adc_lo_start),
  .gyro_tick(gyro_tick), .dio_oe(dio_oe), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en), .dac_code(dac_code), .dac_en(dac_en));

// ---- bench/adc_model.sv ----
`timescale 1ns/1ns
module adc_model (
  input wire pclk, // Clock
  input wire presetn, // Reset, active low
  input wire slow, // Answer two cycles later
  input wire hi_start, // Start fine batch
  input wire lo_start, // Start coarse batch
  input wire [111:0] hi_set, // Fine levels
  input wire [23:0] lo_set, // Coarse levels
  output reg hi_valid, // Fine results present
  output reg [111:0] hi_data, // Fine results
  output reg lo_valid, // Coarse results present
  output reg [23:0] lo_data // Coarse results
);
  reg [1:0] hi_w;
  reg [1:0] lo_w;
  // Data toggles outside valid so a stale result can never be mistaken for fresh
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_w <= 2'h0;
      lo_w <= 2'h0;
      hi_valid <= 1'b0;
      lo_valid <= 1'b0;
      hi_data <= 112'h0;
      lo_data <= 24'h000000;
    end else begin
      hi_w <= hi_start ? (slow ? 2'h3 : 2'h1) : (hi_w != 2'h0 ? hi_w - 2'h1 : 2'h0);
      lo_w <= lo_start ? (slow ? 2'h3 : 2'h1) : (lo_w != 2'h0 ? lo_w - 2'h1 : 2'h0);
      hi_valid <= hi_w == 2'h1;
      lo_valid <= lo_w == 2'h1;
      hi_data <= hi_w == 2'h1 ? hi_set : ~hi_data;
      lo_data <= lo_w == 2'h1 ? lo_set : ~lo_data;
    end
  end
endmodule // adc_model

// ---- bench/analog_filter_gyro_integrator_bench.sv ----
`timescale 1ns/1ns
module analog_filter_gyro_integrator_bench;
  reg pclk, presetn, psel, penable, pwrite, slow, gyro_on;
  reg [7:0] paddr, dv;
  reg [31:0] pwdata, acc_m, t_m;
  reg [111:0] hi_set;
  reg [23:0] lo_set;
  reg [19:0] dio_in;
  reg [15:0] y1;
  reg [3:0] sh1;
  reg signed [16:0] d1;
  reg [32:0] e;
  reg [32:0] q[$];
  integer n_errors, tests_run, seed, i;
  wire pready, pslverr, hs, hv, ls, lv, dac_en, gyro_tick;
  wire [31:0] prdata;
  wire [111:0] hd;
  wire [23:0] ld;
  wire [19:0] dio_out, dio_oe, pull_up_en, pull_down_en;
  wire [7:0] dac_code;
  io_conditioner #(.HI_SAMPLE_CYCLES(20), .LO_SAMPLE_CYCLES(5), .GYRO_TICK_CYCLES(50)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .adc_hi_start(hs), .adc_hi_valid(hv), .adc_hi_data(hd), .adc_lo_start(ls),
    .adc_lo_valid(lv), .adc_lo_data(ld), .dio_in(dio_in), .dio_out(dio_out),
    .dio_oe(dio_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .dac_code(dac_code), .dac_en(dac_en), .gyro_tick(gyro_tick));
  adc_model adc (.pclk(pclk), .presetn(presetn), .slow(slow), .hi_start(hs), .lo_start(ls),
    .hi_set(hi_set), .lo_set(lo_set), .hi_valid(hv), .hi_data(hd), .lo_valid(lv),
    .lo_data(ld));
  task chk(input string nm, input [31:0] ex, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== ex) begin
        n_errors = n_errors + 1;
        $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task apb(input bit w, input [7:0] a, input [31:0] d, input [32:0] ex);
    begin
      q.push_back(ex);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Result checker: {error, data} noted per transfer, taken at the access edge
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      e = q.pop_front();
      chk("prdata", e[31:0], prdata);
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
    end
    if (gyro_tick)
      t_m <= t_m + 32'h1;
    if (gyro_tick && gyro_on)
      acc_m <= acc_m + {16'h0, hi_set[111:98], 2'b00} - 32'h00008000;
    if (hv) begin
      d1 = $signed({1'b0, hd[27:14], 2'b00}) - $signed({1'b0, y1});
      y1 <= y1 + 16'(d1 >>> sh1);
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors = n_errors + 1;
    test_done;
  end
  initial begin
    seed = 13;
    n_errors = 0;
    tests_run = 0;
    {t_m, acc_m, y1, sh1, gyro_on} = 0;
    presetn <= 1'b0;
    {psel, penable, pwrite, slow} <= 4'h0;
    paddr <= 8'h00;
    pwdata <= 32'h00000000;
    for (i = 0; i < 7; i++)
      hi_set[14*i+:14] <= 14'($random(seed));
    // Gyro level below midscale: the reading is added and the sum still wraps under zero
    hi_set[111:98] <= 14'h1000;
    lo_set <= 24'($random(seed));
    dio_in <= 20'($random(seed));
    dv = 8'($random(seed));
    repeat (12) @(posedge pclk);
    chk("dio_oe", 32'h0, {12'h0, dio_oe});
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 11; i++)
      if (i != 5 && i != 7 && i != 8) apb(0, 8'(4 * i), 0, 33'h0);
    apb(0, 8'h2C, 0, {1'b1, 32'h0});
    apb(1, 8'h3C, 32'hFFFFFFFF, {1'b1, 32'h0});
    apb(1, 8'h14, 32'h000FFFFF, 33'h0);
    apb(0, 8'h14, 0, {13'h0, dio_in});
    apb(1, 8'h18, {24'h0, dv}, 33'h0);
    chk("dac_code", {24'h0, dv}, {24'h0, dac_code});
    apb(0, 8'h18, 0, {25'h0, dv});
    // Start right after a tick so the enable cannot straddle one
    @(posedge pclk iff gyro_tick);
    apb(1, 8'h00, 32'h83000400, 33'h0);
    gyro_on <= 1'b1;
    apb(1, 8'h08, 32'h00000210, 33'h0);
    apb(1, 8'h10, 32'h000FFFFF, 33'h0);
    chk("dio_oe", 32'h20, {12'h0, dio_oe});
    chk("dio_out", 32'h1, {31'h0, dio_out[5]});
    chk("pull_up_en", 32'h4, {12'h0, pull_up_en});
    chk("pull_down_en", 32'h10, {12'h0, pull_down_en});
    chk("dac_en", 32'h1, {31'h0, dac_en});
    apb(1, 8'h00, 32'h83000000, 33'h0);
    chk("dio_oe", 32'h0, {12'h0, dio_oe});
    apb(0, 8'h40, 0, {17'h0, hi_set[13:0], 2'b00});
    apb(0, 8'h60, 0, {17'h0, lo_set[5:0], lo_set[5:0], lo_set[5:2]});
    slow <= 1'b1;
    @(posedge pclk iff hv);
    apb(1, 8'h24, 32'h00000F30, 33'h0);
    sh1 <= 4'h3;
    hi_set[27:14] <= ~hi_set[27:14];
    apb(0, 8'h24, 0, 33'h00F30);
    repeat (4) @(posedge pclk iff hv);
    @(posedge pclk);
    apb(0, 8'h44, 0, {17'h0, y1});
    repeat (2) @(posedge pclk iff gyro_tick);
    @(posedge pclk);
    apb(0, 8'h1C, 0, {1'b0, acc_m});
    apb(0, 8'h20, 0, {1'b0, t_m});
    test_done;
  end
endmodule // analog_filter_gyro_integrator_bench
